// ---- tolwm_top.v ----
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tolwm_map.vh"
// How it works
// [RQ1] the observed value is picked from signal reference 0..47 by a 16-bit selector.
// [RQ2] a second hold-channel reference is picked and kept at each new extreme of the observed value.
// [RQ3] a rising start flag (0..63, 8-bit selector) begins evaluation and a rising stop flag ends it.
// [RQ4] max, min, peak-to-peak and mean go as signed 16-bit words to output references 21..26, 48 meaning none.
// [RQ5] the hold value seen when the observed value hit its maximum is an output.
// [RQ6] the hold value seen when the observed value hit its minimum is an output.
// [RQ7] a duration output counts milliseconds since the start flag.
// [RQ8] the upper flag is set while the observed value is above the high threshold; the code sets it only while an evaluation runs.
// [RQ9] the lower flag is set while the observed value is below the low threshold; the code sets it only while an evaluation runs.
// [RQ10] each threshold flag is driven onto output flag 12..19, 64 meaning none.
// [RQ11] a new evaluation clears all results, and peak-to-peak is max minus min.
module tolwm_top #(
  parameter MS_CYCLES = `TOLWM_MS_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [767:0] sig_in,
  input wire [63:0] flag_in,
  output reg [95:0] sig_out,
  output reg [5:0] sig_out_valid,
  output reg [7:0] flag_out,
  output reg irq
);
  // ****************************************
  // helpers
  // ****************************************
  function [15:0] sig_pick;
    input [767:0] bus;
    input [15:0] sel;
    begin
      if (sel <= `TOLWM_SIG_MAX)
        sig_pick = bus[sel[5:0]*16 +: 16];
      else
        sig_pick = 16'h0000;
    end
  endfunction
  function flag_pick;
    input [63:0] bus;
    input [7:0] sel;
    begin
      if (sel <= `TOLWM_FLAG_IN_MAX)
        flag_pick = bus[sel[5:0]];
      else
        flag_pick = 1'b0;
    end
  endfunction

  // ****************************************
  // configuration registers
  // ****************************************
  reg [15:0] obs_sel_r, hold_sel_r, upper_sel_r, lower_sel_r;
  reg [7:0] start_sel_r, stop_sel_r;
  reg [15:0] max_route_r, min_route_r, span_route_r, cmax_route_r;
  reg [15:0] cmin_route_r, mean_route_r, dur_route_r;
  reg [7:0] uflag_route_r, lflag_route_r;
  reg [3:0] stat_r, mask_r;

  // ****************************************
  // evaluation state
  // ****************************************
  reg running_r, first_r, start_d_r, stop_d_r;
  reg signed [15:0] max_r, min_r, mean_r;
  reg [15:0] cmax_r, cmin_r, dur_r;
  reg signed [47:0] sum_r;
  reg [31:0] cnt_r;
  reg [31:0] tick_r;
  reg upper_r, lower_r;
  reg mean_neg_r;

  wire signed [15:0] x;
  wire [15:0] hold_v;
  wire signed [15:0] hi_v, lo_v;
  wire start_lvl, stop_lvl, start_ev, stop_ev;
  wire signed [15:0] span_v;
  wire upper_nxt, lower_nxt;
  assign x = sig_pick(sig_in, obs_sel_r); // RQ1
  assign hold_v = sig_pick(sig_in, hold_sel_r); // RQ2
  assign hi_v = sig_pick(sig_in, upper_sel_r);
  assign lo_v = sig_pick(sig_in, lower_sel_r);
  assign start_lvl = flag_pick(flag_in, start_sel_r);
  assign stop_lvl = flag_pick(flag_in, stop_sel_r);
  assign start_ev = start_lvl & ~start_d_r; // RQ3
  assign stop_ev = stop_lvl & ~stop_d_r & running_r; // RQ3
  assign span_v = max_r - min_r; // RQ11
  assign upper_nxt = running_r & (x > hi_v); // RQ8
  assign lower_nxt = running_r & (x < lo_v); // RQ9

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_r <= 1'b0;
      first_r <= 1'b0;
      start_d_r <= 1'b0;
      stop_d_r <= 1'b0;
      max_r <= 16'sh0000;
      min_r <= 16'sh0000;
      cmax_r <= 16'h0000;
      cmin_r <= 16'h0000;
      sum_r <= 48'sh0;
      cnt_r <= 32'h0;
      tick_r <= 32'h0;
      dur_r <= 16'h0000;
      upper_r <= 1'b0;
      lower_r <= 1'b0;
    end else begin
      start_d_r <= start_lvl;
      stop_d_r <= stop_lvl;
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
      if (start_ev) begin
        running_r <= 1'b1; // RQ3
        first_r <= 1'b1;
        max_r <= 16'sh0000; // RQ11
        min_r <= 16'sh0000;
        cmax_r <= 16'h0000;
        cmin_r <= 16'h0000;
        sum_r <= 48'sh0;
        cnt_r <= 32'h0;
        tick_r <= 32'h0;
        dur_r <= 16'h0000;
      end else if (stop_ev) begin
        running_r <= 1'b0; // RQ3
      end else if (running_r) begin
        first_r <= 1'b0;
        if (first_r || x > max_r) begin
          max_r <= x;
          cmax_r <= hold_v; // RQ5
        end
        if (first_r || x < min_r) begin
          min_r <= x;
          cmin_r <= hold_v; // RQ6
        end
        sum_r <= sum_r + {{32{x[15]}}, x};
        if (cnt_r != 32'hffffffff)
          cnt_r <= cnt_r + 32'h1;
        if (tick_r == MS_CYCLES - 1) begin
          tick_r <= 32'h0;
          if (dur_r != `TOLWM_DUR_SAT)
            dur_r <= dur_r + 16'h0001; // RQ7
        end else begin
          tick_r <= tick_r + 32'h1;
        end
      end
    end
  end

  // ****************************************
  // mean by serial division
  // ****************************************
  wire div_busy, div_done;
  wire [47:0] div_quo;
  wire div_go;
  wire [47:0] sum_abs;
  assign sum_abs = sum_r[47] ? 48'h0 - sum_r : sum_r;
  assign div_go = running_r & ~start_ev & (cnt_r != 32'h0) & ~div_busy;

  tolwm_div #(.NW(48), .DW(32)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(div_go),
    .num(sum_abs),
    .den(cnt_r),
    .busy_r(div_busy),
    .done_r(div_done),
    .quo_r(div_quo)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mean_r <= 16'sh0000;
      mean_neg_r <= 1'b0;
    end else begin
      if (div_go)
        mean_neg_r <= sum_r[47];
      if (start_ev)
        mean_r <= 16'sh0000; // RQ11
      else if (div_done)
        mean_r <= mean_neg_r ? 16'h0000 - div_quo[15:0] : div_quo[15:0];
    end
  end

  // ****************************************
  // output routing
  // ****************************************
  reg [95:0] sig_out_nxt;
  reg [5:0] sig_valid_nxt;
  reg [7:0] flag_nxt;
  integer i;
  always @* begin
    sig_out_nxt = 96'h0;
    sig_valid_nxt = 6'h00;
    flag_nxt = 8'h00;
    for (i = 5; i >= 0; i = i - 1) begin
      if (dur_route_r == `TOLWM_ROUTE_LO + i) begin
        sig_out_nxt[i*16 +: 16] = dur_r; // RQ7
        sig_valid_nxt[i] = 1'b1;
      end
      if (mean_route_r == `TOLWM_ROUTE_LO + i) begin
        sig_out_nxt[i*16 +: 16] = mean_r; // RQ4
        sig_valid_nxt[i] = 1'b1;
      end
      if (cmin_route_r == `TOLWM_ROUTE_LO + i) begin
        sig_out_nxt[i*16 +: 16] = cmin_r; // RQ6
        sig_valid_nxt[i] = 1'b1;
      end
      if (cmax_route_r == `TOLWM_ROUTE_LO + i) begin
        sig_out_nxt[i*16 +: 16] = cmax_r; // RQ5
        sig_valid_nxt[i] = 1'b1;
      end
      if (span_route_r == `TOLWM_ROUTE_LO + i) begin
        sig_out_nxt[i*16 +: 16] = span_v; // RQ4
        sig_valid_nxt[i] = 1'b1;
      end
      if (min_route_r == `TOLWM_ROUTE_LO + i) begin
        sig_out_nxt[i*16 +: 16] = min_r; // RQ4
        sig_valid_nxt[i] = 1'b1;
      end
      if (max_route_r == `TOLWM_ROUTE_LO + i) begin
        sig_out_nxt[i*16 +: 16] = max_r; // RQ4
        sig_valid_nxt[i] = 1'b1;
      end
    end
    for (i = 0; i < 8; i = i + 1) begin
      if (uflag_route_r == `TOLWM_FLAG_LO + i)
        flag_nxt[i] = flag_nxt[i] | upper_r; // RQ10
      if (lflag_route_r == `TOLWM_FLAG_LO + i)
        flag_nxt[i] = flag_nxt[i] | lower_r; // RQ10
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_out <= 96'h0;
      sig_out_valid <= 6'h00;
      flag_out <= 8'h00;
    end else begin
      sig_out <= sig_out_nxt;
      sig_out_valid <= sig_valid_nxt;
      flag_out <= flag_nxt;
    end
  end

  // ****************************************
  // apb slave and interrupt
  // ****************************************
  wire acc, wr;
  reg [31:0] rd_nxt;
  reg hit_nxt;
  wire [3:0] ev;
  assign acc = psel & penable & ~pready;
  assign wr = psel & penable & pready & pwrite & ~pslverr;
  assign ev = {lower_nxt & ~lower_r, upper_nxt & ~upper_r, stop_ev, start_ev};

  always @* begin
    rd_nxt = 32'h0;
    hit_nxt = 1'b1;
    case (paddr)
      `TOLWM_OBS_SEL: rd_nxt = {16'h0, obs_sel_r};
      `TOLWM_HOLD_SEL: rd_nxt = {16'h0, hold_sel_r};
      `TOLWM_UPPER_SEL: rd_nxt = {16'h0, upper_sel_r};
      `TOLWM_LOWER_SEL: rd_nxt = {16'h0, lower_sel_r};
      `TOLWM_START_SEL: rd_nxt = {24'h0, start_sel_r};
      `TOLWM_STOP_SEL: rd_nxt = {24'h0, stop_sel_r};
      `TOLWM_MAX_ROUTE: rd_nxt = {16'h0, max_route_r};
      `TOLWM_MIN_ROUTE: rd_nxt = {16'h0, min_route_r};
      `TOLWM_SPAN_ROUTE: rd_nxt = {16'h0, span_route_r};
      `TOLWM_CMAX_ROUTE: rd_nxt = {16'h0, cmax_route_r};
      `TOLWM_CMIN_ROUTE: rd_nxt = {16'h0, cmin_route_r};
      `TOLWM_MEAN_ROUTE: rd_nxt = {16'h0, mean_route_r};
      `TOLWM_DUR_ROUTE: rd_nxt = {16'h0, dur_route_r};
      `TOLWM_UFLAG_ROUTE: rd_nxt = {24'h0, uflag_route_r};
      `TOLWM_LFLAG_ROUTE: rd_nxt = {24'h0, lflag_route_r};
      `TOLWM_IRQ_STAT: rd_nxt = {28'h0, stat_r};
      `TOLWM_IRQ_MASK: rd_nxt = {28'h0, mask_r};
      `TOLWM_STATE: rd_nxt = {29'h0, lower_r, upper_r, running_r};
      default: hit_nxt = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      irq <= 1'b0;
      stat_r <= 4'h0;
      mask_r <= 4'h0;
      obs_sel_r <= 16'h0000;
      hold_sel_r <= 16'h0000;
      upper_sel_r <= 16'h0000;
      lower_sel_r <= 16'h0000;
      start_sel_r <= 8'h00;
      stop_sel_r <= 8'h00;
      max_route_r <= `TOLWM_ROUTE_NONE;
      min_route_r <= `TOLWM_ROUTE_NONE;
      span_route_r <= `TOLWM_ROUTE_NONE;
      cmax_route_r <= `TOLWM_ROUTE_NONE;
      cmin_route_r <= `TOLWM_ROUTE_NONE;
      mean_route_r <= `TOLWM_ROUTE_NONE;
      dur_route_r <= `TOLWM_ROUTE_NONE;
      uflag_route_r <= `TOLWM_FLAG_NONE;
      lflag_route_r <= `TOLWM_FLAG_NONE;
    end else begin
      pready <= acc;
      pslverr <= acc & ~hit_nxt;
      if (acc) begin
        prdata <= pwrite ? 32'h0 : rd_nxt;
      end
      // set wins over write-one-to-clear
      stat_r <= (stat_r & ~(wr && paddr == `TOLWM_IRQ_STAT ? pwdata[3:0] : 4'h0)) | ev;
      irq <= |(stat_r & mask_r);
      if (wr) begin
        case (paddr)
          `TOLWM_OBS_SEL: obs_sel_r <= pwdata[15:0];
          `TOLWM_HOLD_SEL: hold_sel_r <= pwdata[15:0];
          `TOLWM_UPPER_SEL: upper_sel_r <= pwdata[15:0];
          `TOLWM_LOWER_SEL: lower_sel_r <= pwdata[15:0];
          `TOLWM_START_SEL: start_sel_r <= pwdata[7:0];
          `TOLWM_STOP_SEL: stop_sel_r <= pwdata[7:0];
          `TOLWM_MAX_ROUTE: max_route_r <= pwdata[15:0];
          `TOLWM_MIN_ROUTE: min_route_r <= pwdata[15:0];
          `TOLWM_SPAN_ROUTE: span_route_r <= pwdata[15:0];
          `TOLWM_CMAX_ROUTE: cmax_route_r <= pwdata[15:0];
          `TOLWM_CMIN_ROUTE: cmin_route_r <= pwdata[15:0];
          `TOLWM_MEAN_ROUTE: mean_route_r <= pwdata[15:0];
          `TOLWM_DUR_ROUTE: dur_route_r <= pwdata[15:0];
          `TOLWM_UFLAG_ROUTE: uflag_route_r <= pwdata[7:0];
          `TOLWM_LFLAG_ROUTE: lflag_route_r <= pwdata[7:0];
          `TOLWM_IRQ_MASK: mask_r <= pwdata[3:0];
          default: mask_r <= mask_r;
        endcase
      end
    end
  end
endmodule // tolwm_top
`default_nettype wire

// ---- tolwm_map.vh ----
`ifndef TOLWM_MAP_VH
`define TOLWM_MAP_VH
// ****************************************
// register byte offsets
// ****************************************
`define TOLWM_OBS_SEL 12'h000
`define TOLWM_HOLD_SEL 12'h004
`define TOLWM_UPPER_SEL 12'h008
`define TOLWM_LOWER_SEL 12'h00c
`define TOLWM_START_SEL 12'h010
`define TOLWM_STOP_SEL 12'h014
`define TOLWM_MAX_ROUTE 12'h018
`define TOLWM_MIN_ROUTE 12'h01c
`define TOLWM_SPAN_ROUTE 12'h020
`define TOLWM_CMAX_ROUTE 12'h024
`define TOLWM_CMIN_ROUTE 12'h028
`define TOLWM_MEAN_ROUTE 12'h02c
`define TOLWM_DUR_ROUTE 12'h030
`define TOLWM_UFLAG_ROUTE 12'h034
`define TOLWM_LFLAG_ROUTE 12'h038
`define TOLWM_IRQ_STAT 12'h040
`define TOLWM_IRQ_MASK 12'h044
`define TOLWM_STATE 12'h048
// ****************************************
// ranges and reset values
// ****************************************
`define TOLWM_SIG_MAX 16'h002f
`define TOLWM_FLAG_IN_MAX 8'h3f
`define TOLWM_ROUTE_LO 16'h0015
`define TOLWM_ROUTE_HI 16'h001a
`define TOLWM_ROUTE_NONE 16'h0030
`define TOLWM_FLAG_LO 8'h0c
`define TOLWM_FLAG_HI 8'h13
`define TOLWM_FLAG_NONE 8'h40
`define TOLWM_DUR_SAT 16'h7fff
// ****************************************
// status bits
// ****************************************
`define TOLWM_EV_START 0
`define TOLWM_EV_STOP 1
`define TOLWM_EV_UPPER 2
`define TOLWM_EV_LOWER 3
// ****************************************
// timing
// ****************************************
`define TOLWM_MS_NS 1000000
`define TOLWM_CLK_NS 4
`define TOLWM_MS_CYCLES (`TOLWM_MS_NS / `TOLWM_CLK_NS)
`endif

// ---- tolwm_div.v ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial unsigned divider
// ****************************************
module tolwm_div #(
  parameter NW = 48,
  parameter DW = 32
) (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [NW-1:0] num,
  input wire [DW-1:0] den,
  output reg busy_r,
  output reg done_r,
  output reg [NW-1:0] quo_r
);
  reg [DW:0] rem_r;
  reg [DW-1:0] den_r;
  reg [7:0] cnt_r;
  wire [DW:0] trial;
  assign trial = {rem_r[DW-1:0], quo_r[NW-1]} - {1'b0, den_r};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      quo_r <= {NW{1'b0}};
      rem_r <= {(DW+1){1'b0}};
      den_r <= {DW{1'b0}};
      cnt_r <= 8'h00;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && start) begin
        busy_r <= 1'b1;
        quo_r <= num;
        den_r <= den;
        rem_r <= {(DW+1){1'b0}};
        cnt_r <= NW[7:0];
      end else if (busy_r) begin
        if (trial[DW]) begin
          rem_r <= {rem_r[DW-1:0], quo_r[NW-1]};
          quo_r <= {quo_r[NW-2:0], 1'b0};
        end else begin
          rem_r <= trial;
          quo_r <= {quo_r[NW-2:0], 1'b1};
        end
        cnt_r <= cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule // tolwm_div
`default_nettype wire

// ---- tolwm_chk_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module tolwm_chk #(
  parameter MS_CYCLES = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [95:0] sig_out,
  input wire logic [5:0] sig_out_valid,
  input wire logic [7:0] flag_out,
  input wire logic irq
);
  logic wr_q_r;
  // write seen at the previous edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q_r <= 1'b0;
    end else begin
      wr_q_r <= psel && pwrite;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_late: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready not in second access cycle");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_zero_data: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0)
    else $error("prdata not zero");
  chk_rdata_hold: assert property (!psel |-> ##1 $stable(prdata))
    else $error("prdata moved while idle");
  chk_reset_quiet: assert property ($rose(presetn) |-> !pready && !irq && sig_out == 96'h0 && flag_out == 8'h0)
    else $error("outputs not quiet after reset");
  chk_valid_route: assert property (!$stable(sig_out_valid) |-> wr_q_r || $past(wr_q_r))
    else $error("slot validity moved without a write");
  cover property (pready && pslverr);
  cover property ($rose(irq));
  cover property (sig_out_valid == 6'h3f);
endmodule // tolwm_chk
bind tolwm_top tolwm_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .sig_out(sig_out),
  .sig_out_valid(sig_out_valid),
  .flag_out(flag_out),
  .irq(irq)
);
`default_nettype wire

// ---- tolwm_far.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// signal references and flags
// ****
module tolwm_far (
  input wire logic pclk,
  output var logic [767:0] sig_in,
  output var logic [63:0] flag_in
);
  logic [15:0] want [48];
  logic [47:0] held;
  logic [63:0] want_flag;
  initial begin
    sig_in = {48{16'h0f0f}};
    flag_in = 64'h0;
    held = 48'h0;
    want_flag = 64'h0;
  end
  // unused references wander so a wrong selector shows
  always @(posedge pclk) begin
    for (int i = 0; i < 48; i++) begin
      sig_in[i*16 +: 16] <= held[i] ? want[i] : sig_in[i*16 +: 16] + 16'h1111;
    end
    flag_in <= want_flag;
  end
  task put_sig(input int n, input logic [15:0] v);
    want[n] <= v;
    held[n] <= 1'b1;
  endtask
  task put_flag(input int n, input logic b);
    want_flag[n] <= b;
  endtask
endmodule // tolwm_far
`default_nettype wire

// ---- test_tolerance_window_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tolwm_map.vh"
// ****
// bench
// ****
module test_tolerance_window_monitor;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] rst;
    logic [31:0] wdat;
    logic [31:0] back;
  } tolwm_row_t;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  wire [767:0] sig_in;
  wire [63:0] flag_in;
  wire [95:0] sig_out;
  wire [5:0] sig_out_valid;
  wire [7:0] flag_out;
  int n_errors, checks;
  tolwm_row_t rows [15];
  always #2 pclk = ~pclk;
  tolwm_top #(.MS_CYCLES(10)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sig_in(sig_in), .flag_in(flag_in), .sig_out(sig_out), .sig_out_valid(sig_out_valid),
    .flag_out(flag_out), .irq(irq)
  );
  tolwm_far u_far (.pclk(pclk), .sig_in(sig_in), .flag_in(flag_in));
  task automatic wrap_up;
    if (n_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic slot(input int k, input logic [15:0] e);
    check({16'h0, sig_out[k*16 +: 16]}, {16'h0, e});
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    n_errors = 0;
    checks = 0;
    rows[0] = {`TOLWM_OBS_SEL, 32'h0, 32'h2f, 32'h2f};
    rows[1] = {`TOLWM_HOLD_SEL, 32'h0, 32'h1, 32'h1};
    rows[2] = {`TOLWM_UPPER_SEL, 32'h0, 32'h2, 32'h2};
    rows[3] = {`TOLWM_LOWER_SEL, 32'h0, 32'h3, 32'h3};
    rows[4] = {`TOLWM_START_SEL, 32'h0, 32'h3f, 32'h3f};
    rows[5] = {`TOLWM_STOP_SEL, 32'h0, 32'h0, 32'h0};
    rows[6] = {`TOLWM_MAX_ROUTE, 32'h30, 32'hffff_0015, 32'h15};
    rows[7] = {`TOLWM_MIN_ROUTE, 32'h30, 32'h16, 32'h16};
    rows[8] = {`TOLWM_SPAN_ROUTE, 32'h30, 32'h17, 32'h17};
    rows[9] = {`TOLWM_CMAX_ROUTE, 32'h30, 32'h18, 32'h18};
    rows[10] = {`TOLWM_CMIN_ROUTE, 32'h30, 32'h19, 32'h19};
    rows[11] = {`TOLWM_MEAN_ROUTE, 32'h30, 32'h1a, 32'h1a};
    rows[12] = {`TOLWM_UFLAG_ROUTE, 32'h40, 32'h0c, 32'h0c};
    rows[13] = {`TOLWM_LFLAG_ROUTE, 32'h40, 32'h13, 32'h13};
    rows[14] = {`TOLWM_IRQ_MASK, 32'h0, 32'hf, 32'hf};
    u_far.put_sig(47, 16'd10);
    u_far.put_sig(1, 16'd7);
    u_far.put_sig(2, 16'd100);
    u_far.put_sig(3, 16'hff9c);
    tick(10);
    presetn <= 1'b1;
    tick(1);
    check({17'h0, irq, flag_out, sig_out_valid}, 32'h0);
    for (int i = 0; i < 15; i++) begin
      rdchk(rows[i].addr, rows[i].rst);
      wr(rows[i].addr, rows[i].wdat);
      rdchk(rows[i].addr, rows[i].back);
    end
    apb(1'b1, 12'h03c, 32'hffff_ffff);
    check({31'h0, err}, 32'h1);
    rdchk(12'h0fc, 32'h0);
    check({31'h0, err}, 32'h1);
    // first window: both extremes and both flags
    u_far.put_flag(63, 1'b1);
    tick(8);
    u_far.put_sig(47, 16'd150);
    u_far.put_sig(1, 16'd11);
    tick(8);
    check({24'h0, flag_out}, 32'h01);
    u_far.put_sig(47, 16'hff88);
    u_far.put_sig(1, 16'd22);
    tick(8);
    check({24'h0, flag_out}, 32'h80);
    u_far.put_sig(47, 16'd20);
    u_far.put_flag(0, 1'b1);
    tick(8);
    slot(0, 16'd150);
    slot(1, 16'hff88);
    slot(2, 16'd270);
    slot(3, 16'd11);
    slot(4, 16'd22);
    check({26'h0, sig_out_valid}, 32'h3f);
    u_far.put_sig(47, 16'd500);
    tick(8);
    slot(0, 16'd150);
    check({24'h0, flag_out}, 32'h0);
    rdchk(`TOLWM_IRQ_STAT, 32'hf);
    check({31'h0, irq}, 32'h1);
    wr(`TOLWM_IRQ_MASK, 32'h0);
    tick(3);
    check({31'h0, irq}, 32'h0);
    wr(`TOLWM_IRQ_MASK, 32'h2);
    wr(`TOLWM_IRQ_STAT, 32'hd);
    rdchk(`TOLWM_IRQ_STAT, 32'h2);
    check({31'h0, irq}, 32'h1);
    wr(`TOLWM_IRQ_STAT, 32'h2);
    rdchk(`TOLWM_IRQ_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
    // second window: results start afresh
    u_far.put_flag(63, 1'b0);
    u_far.put_flag(0, 1'b0);
    u_far.put_sig(47, 16'd37);
    u_far.put_sig(1, 16'd5);
    tick(4);
    u_far.put_flag(63, 1'b1);
    tick(4);
    rdchk(`TOLWM_STATE, 32'h1);
    tick(190);
    u_far.put_flag(0, 1'b1);
    tick(8);
    slot(0, 16'd37);
    slot(1, 16'd37);
    slot(2, 16'd0);
    slot(3, 16'd5);
    slot(4, 16'd5);
    slot(5, 16'd37);
    rdchk(`TOLWM_STATE, 32'h0);
    wr(`TOLWM_MEAN_ROUTE, 32'h30);
    wr(`TOLWM_DUR_ROUTE, 32'h1a);
    tick(4);
    check({31'h0, sig_out[80 +: 16] >= 16'd18 && sig_out[80 +: 16] <= 16'd21}, 32'h1);
    // reset after the second window has stopped: routes fall back to none
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    tick(1);
    check({17'h0, irq, flag_out, sig_out_valid}, 32'h0);
    rdchk(`TOLWM_DUR_ROUTE, 32'h30);
    rdchk(`TOLWM_LFLAG_ROUTE, 32'h40);
    wrap_up();
  end
endmodule // test_tolerance_window_monitor
`default_nettype wire
